/* logic/uied_top.sv */
// Behaviour
// - X buffer start address is programmed field as bits 10:3, low bits zero.
// - Y buffer start address is formed the same way from its own field.
// - transactions start at the base and never alter the base field.
// - byte count is the low seven bits, 0 to 64; bit 7 excluded.
// - bit 7 of a count register is NAK; set means empty, host is NAKed.
// - one seven-bit size serves X and Y; bit 7 reads zero.
// - endpoint 0 uses four dedicated configuration and count registers.
// - endpoint 0 buffers are fixed at fef8h (in) and fef0h (out).
// - endpoint 0 registers decode at ff80h, ff81h, ff82h and ff83h.
// - endpoint 0 configuration bits sit where endpoints 1 to 3 have them.
// - bit 2 enables a completion interrupt; clear gives none; resets 0.
// - stall bit 3 answers STALL; on endpoint 0 it clears on the next setup.
// - bit 5 shows endpoint 0 data toggle, read only, resets 0.
// - buffer manager serves endpoint 0 only while bit 7 is set.
// - with double buffering the toggle picks X or Y, else X only.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "uied_defines.svh"

module uied_top
  import uied_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // buffer manager side
  input wire logic in_token,
  input wire logic [1:0] in_ep,
  input wire logic in_ack,
  input wire logic [1:0] ack_ep,
  input wire logic setup_rcvd,
  // answer to an in token
  output logic resp_valid,
  output uied_rsp_e resp_kind,
  output logic [15:0] resp_addr,
  output logic [6:0] resp_count,
  output logic resp_toggle,
  // interrupt
  output logic irq
);

  localparam int NUM_EP = 4;

  logic [7:0] cfg_q [NUM_EP];
  logic [7:0] bax_q [NUM_EP];
  logic [7:0] bay_q [NUM_EP];
  logic [7:0] ctx_q [NUM_EP];
  logic [7:0] cty_q [NUM_EP];
  logic [7:0] siz_q [NUM_EP];
  logic [7:0] out0_cfg_q;
  logic [7:0] out0_cnt_q;
  logic [3:0] stat_q;
  logic [3:0] irq_en_q;
  logic [7:0] rdata_q;
  logic resp_valid_q;
  uied_rsp_e resp_kind_q;
  logic [15:0] resp_addr_q;
  logic [6:0] resp_count_q;
  logic resp_toggle_q;
  logic irq_q;

  uied_rsp_e ep_kind [NUM_EP];
  logic [15:0] ep_addr [NUM_EP];
  logic [6:0] ep_count [NUM_EP];
  logic [NUM_EP-1:0] ep_use_y;
  logic [NUM_EP-1:0] done;
  logic [NUM_EP-1:0] completion_irq_enable;

  // address decode
  wire logic desc_page = reg_addr[15:5] == `UIED_EDB_PAGE;
  wire logic [1:0] desc_ep = reg_addr[4:3];
  wire logic [2:0] desc_off = reg_addr[2:0];
  wire logic desc_hit = desc_page && desc_ep != 2'h0;
  wire logic hit_in0_cfg = reg_addr == `UIED_IN0_CFG;
  wire logic hit_in0_cnt = reg_addr == `UIED_IN0_CNT;
  wire logic hit_out0_cfg = reg_addr == `UIED_OUT0_CFG;
  wire logic hit_out0_cnt = reg_addr == `UIED_OUT0_CNT;
  wire logic hit_stat = reg_addr == `UIED_IRQ_STAT;
  wire logic hit_clr = reg_addr == `UIED_IRQ_CLR;
  wire logic hit_en = reg_addr == `UIED_IRQ_EN;

  wire logic wr_out0_cfg = reg_wr && hit_out0_cfg;
  wire logic wr_out0_cnt = reg_wr && hit_out0_cnt;
  wire logic wr_clr = reg_wr && hit_clr;
  wire logic wr_en = reg_wr && hit_en;

  genvar i;
  generate
    for (i = 0; i < NUM_EP; i++) begin : g_ep
      wire logic sel = desc_hit && desc_ep == 2'(i);
      wire logic is_ep0 = i == 0;
      wire logic wr_cfg = reg_wr && (is_ep0 ? hit_in0_cfg :
        sel && desc_off == `UIED_OFF_CFG);
      wire logic wr_ctx = reg_wr && (is_ep0 ? hit_in0_cnt :
        sel && desc_off == `UIED_OFF_CTX);
      wire logic wr_bax = reg_wr && sel && desc_off == `UIED_OFF_BAX;
      wire logic wr_bay = reg_wr && sel && desc_off == `UIED_OFF_BAY;
      wire logic wr_cty = reg_wr && sel && desc_off == `UIED_OFF_CTY;
      wire logic wr_siz = reg_wr && sel && desc_off == `UIED_OFF_SIZ;
      // endpoint 0 exposes only manager_use_enable, stall and completion_irq_enable to software
      wire logic [7:0] cfg_mask = is_ep0 ? `UIED_EP0_CFG_WMASK :
        `UIED_EPN_CFG_WMASK;
      wire logic [7:0] ctx_mask = is_ep0 ? `UIED_EP0_CNT_MASK : 8'hff;
      wire logic stall_clr = is_ep0 && setup_rcvd;

      assign done[i] = in_ack && ack_ep == 2'(i) &&
        cfg_q[i][`UIED_BIT_MANAGER_USE_ENABLE];
      assign completion_irq_enable[i] = cfg_q[i][`UIED_BIT_COMPLETION_IRQ_ENABLE];

      logic [7:0] cfg_wr_d;
      logic [7:0] cfg_d;
      logic [7:0] ctx_d;
      logic [7:0] cty_d;

      // software fields from the write; toggle is written by software on endpoints 1 to 3, kept by hardware on endpoint 0
      assign cfg_wr_d = wr_cfg ?
        ((reg_wdata & cfg_mask) |
        (cfg_q[i] & ~cfg_mask)) : cfg_q[i];
      always_comb begin
        cfg_d = cfg_wr_d;
        if (stall_clr && !wr_cfg) begin
          cfg_d[`UIED_BIT_STALL] = 1'b0;
        end
        if (done[i]) begin
          cfg_d[`UIED_BIT_TOGGLE] = !cfg_q[i][`UIED_BIT_TOGGLE];
        end
      end

      // completion marks the used buffer empty, overriding a write
      always_comb begin
        ctx_d = wr_ctx ? (reg_wdata & ctx_mask) : ctx_q[i];
        cty_d = wr_cty ? reg_wdata : cty_q[i];
        if (done[i] && !ep_use_y[i]) begin
          ctx_d[`UIED_BIT_NAK] = 1'b1;
        end
        if (done[i] && ep_use_y[i]) begin
          cty_d[`UIED_BIT_NAK] = 1'b1;
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          cfg_q[i] <= `UIED_REG_RST;
          ctx_q[i] <= is_ep0 ? `UIED_EP0_CNT_RST : `UIED_REG_RST;
          cty_q[i] <= `UIED_REG_RST;
        end else begin
          cfg_q[i] <= cfg_d;
          ctx_q[i] <= ctx_d;
          cty_q[i] <= cty_d;
        end
      end

      // base fields change only by software writes
      always_ff @(posedge clock) begin
        if (rst) begin
          bax_q[i] <= `UIED_REG_RST;
          bay_q[i] <= `UIED_REG_RST;
          siz_q[i] <= `UIED_REG_RST;
        end else begin
          if (wr_bax) begin
            bax_q[i] <= reg_wdata;
          end
          if (wr_bay) begin
            bay_q[i] <= reg_wdata;
          end
          if (wr_siz) begin
            siz_q[i] <= reg_wdata & `UIED_SIZE_MASK;
          end
        end
      end

      uied_ep_resolve u_resolve (
        .is_ep0(is_ep0),
        .cfg(cfg_q[i]),
        .bax(bax_q[i]),
        .bay(bay_q[i]),
        .ctx(ctx_q[i]),
        .cty(cty_q[i]),
        .kind(ep_kind[i]),
        .addr(ep_addr[i]),
        .count(ep_count[i]),
        .use_y(ep_use_y[i])
      );
    end
  endgenerate

  // endpoint 0 out registers: storage and setup stall clear only
  wire logic [7:0] out0_cfg_w = (reg_wdata & `UIED_EP0_CFG_WMASK) |
    (out0_cfg_q & ~`UIED_EP0_CFG_WMASK);
  wire logic [7:0] out0_cfg_d = wr_out0_cfg ? out0_cfg_w :
    setup_rcvd ? (out0_cfg_q & ~(8'h01 << `UIED_BIT_STALL)) :
    out0_cfg_q;
  wire logic [7:0] out0_cnt_d = wr_out0_cnt ?
    (reg_wdata & `UIED_EP0_CNT_MASK) : out0_cnt_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      out0_cfg_q <= `UIED_REG_RST;
      out0_cnt_q <= `UIED_EP0_CNT_RST;
    end else begin
      out0_cfg_q <= out0_cfg_d;
      out0_cnt_q <= out0_cnt_d;
    end
  end

  // completion events only where the endpoint enables them
  wire logic [3:0] stat_set = done & completion_irq_enable;
  wire logic [3:0] stat_clr = wr_clr ? reg_wdata[3:0] : 4'h0;
  wire logic [3:0] stat_d = (stat_q & ~stat_clr) | stat_set;
  wire logic [3:0] irq_en_d = wr_en ? reg_wdata[3:0] : irq_en_q;
  wire logic irq_d = |(stat_d & irq_en_d);

  always_ff @(posedge clock) begin
    if (rst) begin
      stat_q <= 4'h0;
      irq_en_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
    end
  end

  // read selection
  wire logic [7:0] desc_rd =
    desc_off == `UIED_OFF_CFG ? cfg_q[desc_ep] :
    desc_off == `UIED_OFF_BAX ? bax_q[desc_ep] :
    desc_off == `UIED_OFF_CTX ? ctx_q[desc_ep] :
    desc_off == `UIED_OFF_BAY ? bay_q[desc_ep] :
    desc_off == `UIED_OFF_CTY ? cty_q[desc_ep] :
    desc_off == `UIED_OFF_SIZ ? siz_q[desc_ep] : 8'h00;
  wire logic [7:0] rd_val =
    desc_hit ? desc_rd :
    hit_in0_cfg ? cfg_q[0] :
    hit_in0_cnt ? ctx_q[0] :
    hit_out0_cfg ? out0_cfg_q :
    hit_out0_cnt ? out0_cnt_q :
    hit_stat ? {4'h0, stat_q} :
    hit_en ? {4'h0, irq_en_q} : 8'h00;

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_val : 8'h00;
    end
  end

  // answer to an in token, one cycle after it
  always_ff @(posedge clock) begin
    if (rst) begin
      resp_valid_q <= 1'b0;
      resp_kind_q <= UIED_RSP_NONE;
      resp_addr_q <= 16'h0000;
      resp_count_q <= 7'h00;
      resp_toggle_q <= 1'b0;
    end else begin
      resp_valid_q <= in_token;
      if (in_token) begin
        resp_kind_q <= ep_kind[in_ep];
        resp_addr_q <= ep_addr[in_ep];
        resp_count_q <= ep_count[in_ep];
        resp_toggle_q <= cfg_q[in_ep][`UIED_BIT_TOGGLE];
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign resp_valid = resp_valid_q;
  assign resp_kind = resp_kind_q;
  assign resp_addr = resp_addr_q;
  assign resp_count = resp_count_q;
  assign resp_toggle = resp_toggle_q;
  assign irq = irq_q;

endmodule

/* logic/uied_defines.svh */
`ifndef UIED_DEFINES_SVH
`define UIED_DEFINES_SVH

// descriptor window for endpoints 1 to 3: base + 8 * n + offset
`define UIED_EDB_PAGE 11'h7fa
`define UIED_OFF_CFG 3'h0
`define UIED_OFF_BAX 3'h1
`define UIED_OFF_CTX 3'h2
`define UIED_OFF_BAY 3'h5
`define UIED_OFF_CTY 3'h6
`define UIED_OFF_SIZ 3'h7

// endpoint-0 and interrupt registers
`define UIED_IN0_CFG 16'hff80
`define UIED_IN0_CNT 16'hff81
`define UIED_OUT0_CFG 16'hff82
`define UIED_OUT0_CNT 16'hff83
`define UIED_IRQ_STAT 16'hff84
`define UIED_IRQ_CLR 16'hff85
`define UIED_IRQ_EN 16'hff86

// hardwired endpoint-0 buffers
`define UIED_EP0_IN_BUF 16'hfef8
`define UIED_EP0_OUT_BUF 16'hfef0

// bit positions shared by all configuration registers; NAK is bit 7 of the count registers
`define UIED_BIT_MANAGER_USE_ENABLE 7
`define UIED_BIT_TOGGLE 5
`define UIED_BIT_DOUBLE_BUFFER_ENABLE 4
`define UIED_BIT_STALL 3
`define UIED_BIT_COMPLETION_IRQ_ENABLE 2
`define UIED_BIT_NAK 7

// write masks and reset values
`define UIED_EP0_CFG_WMASK 8'h8c
`define UIED_EPN_CFG_WMASK 8'hbc
`define UIED_SIZE_MASK 8'h7f
`define UIED_EP0_CNT_MASK 8'h8f
`define UIED_EP0_CNT_RST 8'h80
`define UIED_REG_RST 8'h00
`define UIED_EP0_MAX_CNT 4'h8
`define UIED_BASE_PAD 3'h0

`endif

/* logic/uied_pkg.sv */
package uied_pkg;

  typedef enum logic [1:0] {
    UIED_RSP_NONE,
    UIED_RSP_DATA,
    UIED_RSP_NAK,
    UIED_RSP_STALL
  } uied_rsp_e;

  typedef logic [7:0] uied_byte_t;

endpackage

/* logic/uied_ep_resolve.sv */
`timescale 1ns/1ps
`include "uied_defines.svh"

module uied_ep_resolve
  import uied_pkg::*;
(
  // descriptor contents
  input wire logic is_ep0,
  input wire logic [7:0] cfg,
  input wire logic [7:0] bax,
  input wire logic [7:0] bay,
  input wire logic [7:0] ctx,
  input wire logic [7:0] cty,
  // resolved answer
  output uied_rsp_e kind,
  output logic [15:0] addr,
  output logic [6:0] count,
  output logic use_y
);

  wire logic manager_use_enable = cfg[`UIED_BIT_MANAGER_USE_ENABLE];
  wire logic stall = cfg[`UIED_BIT_STALL];
  wire logic toggle = cfg[`UIED_BIT_TOGGLE];
  wire logic double_buffer_enable = cfg[`UIED_BIT_DOUBLE_BUFFER_ENABLE];

  // buffer chosen by toggle only when double buffered
  assign use_y = !is_ep0 && double_buffer_enable && toggle;

  wire logic [7:0] cnt_reg = use_y ? cty : ctx;
  wire logic nak = cnt_reg[`UIED_BIT_NAK];

  // base field is address bits 10 to 3, low three bits zero
  wire logic [10:0] x_addr = {bax, `UIED_BASE_PAD};
  wire logic [10:0] y_addr = {bay, `UIED_BASE_PAD};
  wire logic [10:0] buf_addr = use_y ? y_addr : x_addr;

  // endpoint 0 counts above eight act as eight
  wire logic [3:0] ep0_cnt = (ctx[3:0] > `UIED_EP0_MAX_CNT) ?
    `UIED_EP0_MAX_CNT : ctx[3:0];

  assign addr = is_ep0 ? `UIED_EP0_IN_BUF : {5'h00, buf_addr};
  assign count = is_ep0 ? {3'h0, ep0_cnt} : cnt_reg[6:0];

  assign kind = !manager_use_enable ? UIED_RSP_NONE :
    stall ? UIED_RSP_STALL :
    nak ? UIED_RSP_NAK : UIED_RSP_DATA;

endmodule

/* tb/uied_top_properties.sv */
`timescale 1ns/1ps
module uied_top_properties
  import uied_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // link side
  input wire logic in_token,
  input wire logic [1:0] in_ep,
  input wire logic in_ack,
  input wire logic resp_valid,
  input wire uied_rsp_e resp_kind,
  input wire logic [15:0] resp_addr,
  input wire logic [6:0] resp_count,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  property p_valid;
    in_token |=> resp_valid;
  endproperty
  property p_pad;
    resp_valid && resp_kind == UIED_RSP_DATA && $past(in_ep) != 2'h0
      |-> resp_addr[2:0] == 3'h0 && resp_addr[15:11] == 5'h00;
  endproperty
  property p_ep0_addr;
    resp_valid && resp_kind == UIED_RSP_DATA && $past(in_ep) == 2'h0
      |-> resp_addr == 16'hfef8;
  endproperty
  property p_count;
    resp_valid && resp_kind == UIED_RSP_DATA |-> resp_count <= 7'h40;
  endproperty
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  property p_cfg0_rsv;
    reg_rd && reg_addr == 16'hff80 |=> (reg_rdata & 8'h53) == 8'h00;
  endproperty
  property p_size_rsv;
    reg_rd && reg_addr[15:5] == 11'h7fa && reg_addr[2:0] == 3'h7
      |=> !reg_rdata[7];
  endproperty
  property p_hold;
    !in_token |=> $stable(resp_addr) && $stable(resp_kind);
  endproperty
  property p_irq_rise;
    $rose(irq) |-> $past(in_ack) || $past(reg_wr);
  endproperty
  property p_irq_fall;
    $fell(irq) |-> $past(reg_wr) || $past(rst);
  endproperty

  a_valid: assert property (p_valid) else $error("no answer");
  a_pad: assert property (p_pad) else $error("bad padding");
  a_ep0_addr: assert property (p_ep0_addr) else $error("ep0 addr");
  a_count: assert property (p_count) else $error("count range");
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata");
  a_cfg0_rsv: assert property (p_cfg0_rsv) else $error("rsv bits");
  a_size_rsv: assert property (p_size_rsv) else $error("size bit7");
  a_hold: assert property (p_hold) else $error("resp moved");
  a_irq_rise: assert property (p_irq_rise) else $error("irq rise");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fall");

  c_data: cover property (resp_valid && resp_kind == UIED_RSP_DATA);
  c_nak: cover property (resp_valid && resp_kind == UIED_RSP_NAK);
  c_stall: cover property (resp_valid && resp_kind == UIED_RSP_STALL);
  c_irq: cover property ($rose(irq));
endmodule

bind uied_top uied_top_properties u_props (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_token(in_token),
  .in_ep(in_ep), .in_ack(in_ack), .resp_valid(resp_valid),
  .resp_kind(resp_kind), .resp_addr(resp_addr), .resp_count(resp_count),
  .irq(irq)
);

/* tb/uied_host_model.sv */
`timescale 1ns/1ps
module uied_host_model
  import uied_pkg::*;
(
  // clock
  input wire logic clock,
  // token, handshake and setup pulses
  output logic in_token = 1'b0,
  output logic [1:0] in_ep = 2'h0,
  output logic in_ack = 1'b0,
  output logic [1:0] ack_ep = 2'h0,
  output logic setup_rcvd = 1'b0
);
  // endpoint lines show the inverse once released
  task automatic token(input logic [1:0] ep);
    @(posedge clock);
    in_token <= 1'b1;
    in_ep <= ep;
    @(posedge clock);
    in_token <= 1'b0;
    in_ep <= ~ep;
  endtask

  // gap of zero acks promptly, larger gaps model a slow host
  task automatic ack(input logic [1:0] ep, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    in_ack <= 1'b1;
    ack_ep <= ep;
    @(posedge clock);
    in_ack <= 1'b0;
    ack_ep <= ~ep;
  endtask

  task automatic setup();
    @(posedge clock);
    setup_rcvd <= 1'b1;
    @(posedge clock);
    setup_rcvd <= 1'b0;
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench
  import uied_pkg::*;
;
  logic clock, rst, reg_wr, reg_rd, in_token, in_ack, setup_rcvd;
  logic resp_valid, resp_toggle, irq;
  logic [15:0] reg_addr, resp_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] in_ep, ack_ep;
  logic [6:0] resp_count;
  uied_rsp_e resp_kind;
  int n_mismatch = 0;
  int compares = 0;

  uied_top DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_token(in_token), .in_ep(in_ep),
    .in_ack(in_ack), .ack_ep(ack_ep), .setup_rcvd(setup_rcvd),
    .resp_valid(resp_valid), .resp_kind(resp_kind),
    .resp_addr(resp_addr), .resp_count(resp_count),
    .resp_toggle(resp_toggle), .irq(irq));
  uied_host_model host (.clock(clock), .in_token(in_token),
    .in_ep(in_ep), .in_ack(in_ack), .ack_ep(ack_ep),
    .setup_rcvd(setup_rcvd));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp));
  endtask

  task automatic tok(input logic [1:0] ep, input uied_rsp_e k,
    input logic [15:0] a, input logic [6:0] c, input logic t);
    host.token(ep);
    #1;
    chk(16'(resp_valid), 16'h0001);
    chk(16'(resp_kind), 16'(k));
    if (k == UIED_RSP_DATA) begin
      chk(resp_addr, a);
      chk(16'(resp_count), 16'(c));
    end
    chk(16'(resp_toggle), 16'(t));
  endtask

  task automatic irq_is(input logic v);
    @(posedge clock);
    #1;
    chk(16'(irq), 16'(v));
  endtask

  task automatic t_reset;
    rdc(16'hff80, 8'h00);
    rdc(16'hff81, 8'h80);
    rdc(16'hff82, 8'h00);
    rdc(16'hff83, 8'h80);
    irq_is(1'b0);
    $display("test reset done");
  endtask

  task automatic t_ep0;
    wr(16'hff86, 8'h01);
    wr(16'hff80, 8'hff);
    wr(16'hff82, 8'hff);
    rdc(16'hff80, 8'h8c);
    tok(2'h0, UIED_RSP_STALL, 16'h0000, 7'h00, 1'b0);
    host.setup();
    rdc(16'hff80, 8'h84);
    rdc(16'hff82, 8'h84);
    tok(2'h0, UIED_RSP_NAK, 16'h0000, 7'h00, 1'b0);
    wr(16'hff81, 8'h05);
    tok(2'h0, UIED_RSP_DATA, 16'hfef8, 7'h05, 1'b0);
    wr(16'hff81, 8'h0c);
    tok(2'h0, UIED_RSP_DATA, 16'hfef8, 7'h08, 1'b0);
    host.ack(2'h0, 3);
    irq_is(1'b1);
    rdc(16'hff80, 8'ha4);
    rdc(16'hff81, 8'h8c);
    rdc(16'hff84, 8'h01);
    wr(16'hff85, 8'h01);
    irq_is(1'b0);
    wr(16'hff80, 8'h00);
    tok(2'h0, UIED_RSP_NONE, 16'h0000, 7'h00, 1'b1);
    host.ack(2'h0, 0);
    rdc(16'hff80, 8'h20);
    $display("test ep0 done");
  endtask

  task automatic t_ep1;
    wr(16'hff48, 8'h94);
    wr(16'hff49, 8'hab);
    wr(16'hff4a, 8'h40);
    wr(16'hff4d, 8'h12);
    wr(16'hff4e, 8'h83);
    wr(16'hff4f, 8'hc0);
    rdc(16'hff4f, 8'h40);
    tok(2'h1, UIED_RSP_DATA, 16'h0558, 7'h40, 1'b0);
    host.ack(2'h1, 0);
    irq_is(1'b0);
    rdc(16'hff49, 8'hab);
    rdc(16'hff4a, 8'hc0);
    tok(2'h1, UIED_RSP_NAK, 16'h0000, 7'h00, 1'b1);
    wr(16'hff4e, 8'h03);
    tok(2'h1, UIED_RSP_DATA, 16'h0090, 7'h03, 1'b1);
    wr(16'hff86, 8'h02);
    irq_is(1'b1);
    wr(16'hff85, 8'h02);
    irq_is(1'b0);
    rdc(16'hff90, 8'h00);
    $display("test ep1 done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_ep0;
    t_ep1;
    wrap_up;
  end

  // whole run needs well under 300 cycles
  initial begin
    repeat (2000) @(posedge clock);
    n_mismatch++;
    $display("watchdog expired");
    wrap_up;
  end
endmodule
